// [rtl/jdr_consts.svh]
/*
 * Reporter offsets, fields, resets, timing.
 * Assumes inclusion by bare name.
 */
`ifndef JDR_CONSTS_SVH
`define JDR_CONSTS_SVH

// ====
// Register byte offsets
`define JDR_OFF_CTRL      8'h00
`define JDR_OFF_BF_CFG    8'h04
`define JDR_OFF_FMI_CFG   8'h08
`define JDR_OFF_CLRCMD    8'h0C
`define JDR_OFF_ACTIVE    8'h10
`define JDR_OFF_LOGGED    8'h14
`define JDR_OFF_DM2       8'h18
`define JDR_OFF_BITFIELD  8'h1C
`define JDR_OFF_STATUS    8'h20

// ====
// Control field positions
`define JDR_CTRL_BF_EN    0
`define JDR_CTRL_FMI_EN   1
`define JDR_CTRL_DM1_EN   2
`define JDR_CTRL_DM2_EN   3
`define JDR_CTRL_DM3_EN   4
`define JDR_CTRL_DM11_EN  5
`define JDR_CTRL_DM13_EN  6
`define JDR_CTRL_DIS_ACT  7
`define JDR_CTRL_DIS_LOG  8
`define JDR_CTRL_SA_LSB   16

// ====
// Reset values
`define JDR_CTRL_RST      32'h0000_0000
`define JDR_BF_CFG_RST    24'h0EEF_00
`define JDR_FMI_CFG_RST   24'h0EAC_FF

// ====
// Fixed codes
`define JDR_ST_NA         2'h3
`define JDR_CLR_GO        2'h1
`define JDR_CLR_IDLE      2'h0
`define JDR_FMI_NONE      5'h1F
`define JDR_TEMP_ZERO     3'h0
`define JDR_TEMP_DERATE   3'h1
`define JDR_TEMP_NORMAL   3'h2
`define JDR_TEMP_ERROR    3'h6
`define JDR_PGN_DM11      18'h0FED3
`define JDR_PGN_DM3       18'h0FECC
`define JDR_PGN_SOFT      18'h0FEDA
`define JDR_SOFT_PRIO     3'h6
`define JDR_SOFT_FIELDS   8'h01
`define JDR_SOFT_DELIM    8'h2A
`define JDR_FILL_BYTE     8'hFF

// ====
// Timing
`define JDR_CLK_HZ        125000000
`define JDR_HOLD_TIME_MS  6000
`define JDR_MAX_ID_LEN    200

`endif

// [rtl/jdr_pkg.sv]
/*
 * Types shared by the diagnostic reporter and its bench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package jdr_pkg;

    // ====
    // Diagnostic condition flags, one bit each
    typedef struct packed {
        logic internal_fault;
        logic run_shutdown;
        logic zero_drive;
        logic loss_demand;
        logic analog_high;
        logic analog_low;
        logic pwm_fail;
        logic can_no_signal;
        logic position_err;
        logic supply_low;
        logic derating;
        logic supply_high;
        logic tracking;
        logic temp_sensor;
        logic spring_check;
        logic can_range;
        logic config_err;
    } jdr_diag_type;

    // ====
    // Parameter group placement
    typedef struct packed {
        logic [2:0]  prio;
        logic [17:0] pgn;
        logic [2:0]  start;
    } jdr_pg_cfg_type;

    // ====
    // One outgoing CAN frame
    typedef struct packed {
        logic        valid;
        logic [28:0] id;
        logic [63:0] data;
    } jdr_frame_type;

    typedef enum {SW_IDLE, SW_SEND} jdr_sw_state_type;

endpackage : jdr_pkg

// [rtl/jdr_reporter.sv]
/*
 * Diagnostic reporter of an actuator node: bit field,
 * failure code, code sets, resets, broadcast stop,
 * identification stream.
 * Assumes ticks, request pulses and flags
 * from the CAN layer, all on clk.
 */
// The implementer's own choices: the address map and register access over Wishbone.
// What this block does
// R1: Bit field: four bytes from start byte.
// R2: Two-bit states: off, on, reserved, absent.
// R3: Byte one: internal, supply, spring, position.
// R4: Byte two: config, sensor, derate, zero drive.
// R5: Byte three: run stop, tracking, demand loss, analog.
// R6: Byte four: PWM, CAN, two pairs at three.
// R7: Set priority in identifier priority field.
// R8: Failure code and temperature status share a byte.
// R9: Only the top-priority failure code shows.
// R10: Codes 12, 5, 0, 14, 15, 17 lead.
// R11: Then 8, 9, 7, 4, 15, 3, 2, 12, 7, 16, 13.
// R12: Temperature status 0 zeroed, 1 derated, 2 normal.
// R13: Status 6 on sensor failure; 3, 4, 5, 7 never.
// R14: New cause sets active and log; clearing drops active.
// R15: First-time entry hidden from logged report.
// R16: DM11 and DM3 act only when enabled.
// R17: Positive or negative acknowledgement.
// R18: Stop and start obeyed; hold restarts the six-second timeout.
// R19: Identification on request only, priority 6.
// R20: Count 1, identifier text, then 0x2A.
// R21: Each report enabled alone; the identification stream has no enable bit and answers a soft_req only when idle, never while a stream is sending.
// R22: Clear acts on command 00 to 01 when not disabled.
// R23: Reports recomputed at each transmit tick.
`include "jdr_consts.svh"

module jdr_reporter #(
    parameter int          ID_LEN      = 8,
    // Arbitrary text
    parameter logic [63:0] SW_ID       = 64'h5357_4944_5F30_3031,
    parameter int          HOLD_CYCLES = `JDR_HOLD_TIME_MS * (`JDR_CLK_HZ / 1000)
) (
    input  wire  logic                  clk,
    input  wire  logic                  rst,
    input  wire  logic                  wb_cyc_i,
    input  wire  logic                  wb_stb_i,
    input  wire  logic                  wb_we_i,
    input  wire  logic [7:0]            wb_adr_i,
    input  wire  logic [3:0]            wb_sel_i,
    input  wire  logic [31:0]           wb_dat_i,
    output logic       [31:0]           wb_dat_o,
    output logic                        wb_ack_o,
    input  wire  jdr_pkg::jdr_diag_type diag_i,
    input  wire  logic                  bf_tick,
    input  wire  logic                  fmi_tick,
    input  wire  logic                  req_dm11,
    input  wire  logic                  req_dm3,
    input  wire  logic                  dm13_stop,
    input  wire  logic                  dm13_start,
    input  wire  logic                  dm13_hold,
    input  wire  logic                  soft_req,
    input  wire  logic                  soft_ready,
    output jdr_pkg::jdr_frame_type      bf_frame_o,
    output jdr_pkg::jdr_frame_type      fmi_frame_o,
    output logic                        ack_valid_o,
    output logic                        ack_pos_o,
    output logic       [17:0]           ack_pgn_o,
    output logic                        bcast_stopped_o,
    output logic                        soft_valid_o,
    output logic       [7:0]            soft_byte_o,
    output logic                        soft_last_o,
    output logic       [28:0]           soft_id_o
);
    import jdr_pkg::*;

    localparam int NDIAG = $bits(jdr_diag_type);

    // ====
    // Elaboration checks
    if (ID_LEN < 1 || ID_LEN > `JDR_MAX_ID_LEN || ID_LEN * 8 > $bits(SW_ID))
        $error("ID_LEN out of range");
    if (HOLD_CYCLES < 2)
        $error("HOLD_CYCLES too small");

    // ====
    // Register file
    logic [31:0]    ctrl_q, ctrl_d;
    jdr_pg_cfg_type bf_cfg_q, bf_cfg_d, fmi_cfg_q, fmi_cfg_d;
    logic [3:0]     clr_q, clr_d;
    logic [31:0]    rdat_q, rdat_d;
    logic           ack_q, ack_d;
    logic           clr_act_cmd, clr_log_cmd;
    logic [NDIAG-1:0] act_q, log_q, first_q, prev_q;
    logic [31:0]    bf_live;
    logic [7:0]     fmi_live;
    logic           stopped_q;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        return r;
    endfunction : merge

    always_comb
    begin
        logic        wr;
        logic [31:0] tmp;
        wr          = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i;
        ack_d       = wb_cyc_i && wb_stb_i && !ack_q;
        ctrl_d      = ctrl_q;
        bf_cfg_d    = bf_cfg_q;
        fmi_cfg_d   = fmi_cfg_q;
        clr_d       = clr_q;
        clr_act_cmd = 1'b0;
        clr_log_cmd = 1'b0;
        tmp         = 32'h0000_0000;
        if (wr)
        begin
            case (wb_adr_i)
                `JDR_OFF_CTRL:    ctrl_d = merge(ctrl_q, wb_dat_i, wb_sel_i);
                `JDR_OFF_BF_CFG:
                begin
                    tmp      = merge({8'h00, bf_cfg_q}, wb_dat_i, wb_sel_i);
                    bf_cfg_d = tmp[23:0];
                end
                `JDR_OFF_FMI_CFG:
                begin
                    tmp       = merge({8'h00, fmi_cfg_q}, wb_dat_i, wb_sel_i);
                    fmi_cfg_d = tmp[23:0];
                end
                `JDR_OFF_CLRCMD:
                begin
                    if (wb_sel_i[0])
                    begin
                        clr_d = wb_dat_i[3:0];
                        // R22 edge 00 to 01
                        clr_act_cmd = clr_q[1:0] == `JDR_CLR_IDLE &&
                                      wb_dat_i[1:0] == `JDR_CLR_GO &&
                                      !ctrl_q[`JDR_CTRL_DIS_ACT];
                        clr_log_cmd = clr_q[3:2] == `JDR_CLR_IDLE &&
                                      wb_dat_i[3:2] == `JDR_CLR_GO &&
                                      !ctrl_q[`JDR_CTRL_DIS_LOG];
                    end
                end
                default: ;
            endcase
        end
        // R21 each report gated alone
        case (wb_adr_i)
            `JDR_OFF_CTRL:     rdat_d = ctrl_q;
            `JDR_OFF_BF_CFG:   rdat_d = {8'h00, bf_cfg_q};
            `JDR_OFF_FMI_CFG:  rdat_d = {8'h00, fmi_cfg_q};
            `JDR_OFF_CLRCMD:   rdat_d = {28'h0, clr_q};
            `JDR_OFF_ACTIVE:
                rdat_d = ctrl_q[`JDR_CTRL_DM1_EN] ? 32'(act_q) : 32'h0;
            // R15 first-time entries hidden
            `JDR_OFF_DM2:
                rdat_d = ctrl_q[`JDR_CTRL_DM2_EN] ? 32'(log_q & ~first_q) : 32'h0;
            `JDR_OFF_LOGGED:   rdat_d = 32'(log_q);
            `JDR_OFF_BITFIELD: rdat_d = bf_live;
            `JDR_OFF_STATUS:   rdat_d = {23'h0, stopped_q, fmi_live};
            default:           rdat_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_q    <= `JDR_CTRL_RST;
            bf_cfg_q  <= `JDR_BF_CFG_RST;
            fmi_cfg_q <= `JDR_FMI_CFG_RST;
            clr_q     <= 4'h0;
            rdat_q    <= 32'h0000_0000;
            ack_q     <= 1'b0;
        end
        else
        begin
            ctrl_q    <= ctrl_d;
            bf_cfg_q  <= bf_cfg_d;
            fmi_cfg_q <= fmi_cfg_d;
            clr_q     <= clr_d;
            rdat_q    <= rdat_d;
            ack_q     <= ack_d;
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;

    // ====
    // Reset requests and diagnostic sets
    logic [NDIAG-1:0] act_d, log_d, first_d, new_det;
    logic             dm11_take, dm3_take, do_clr_act, do_clr_log;
    logic             ackv_q, ackv_d, ackp_q, ackp_d;
    logic [17:0]      ackpgn_q, ackpgn_d;

    always_comb
    begin
        // R16 only when reception enabled
        dm11_take  = req_dm11 && ctrl_q[`JDR_CTRL_DM11_EN];
        dm3_take   = req_dm3 && ctrl_q[`JDR_CTRL_DM3_EN] && !dm11_take;
        do_clr_act = clr_act_cmd || (dm11_take && !ctrl_q[`JDR_CTRL_DIS_ACT]);
        do_clr_log = clr_log_cmd || (dm3_take && !ctrl_q[`JDR_CTRL_DIS_LOG]);
        // R17 answer each taken request
        ackv_d   = dm11_take || dm3_take;
        ackp_d   = dm11_take ? !ctrl_q[`JDR_CTRL_DIS_ACT] :
                               !ctrl_q[`JDR_CTRL_DIS_LOG];
        ackpgn_d = dm11_take ? `JDR_PGN_DM11 : `JDR_PGN_DM3;
        if (!ackv_d)
        begin
            ackp_d   = ackp_q;
            ackpgn_d = ackpgn_q;
        end
        // R14 set both, cause gone drops active
        new_det = diag_i & ~prev_q;
        act_d   = (act_q & diag_i) | new_det;
        log_d   = log_q | new_det;
        // R15 mark first occurrence
        first_d = (first_q & act_d) | (new_det & ~log_q);
        // A fresh detection wins over a clear in the same cycle
        if (do_clr_act)
            act_d = new_det;
        if (do_clr_log)
        begin
            log_d   = new_det;
            first_d = new_det;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            act_q    <= '0;
            log_q    <= '0;
            first_q  <= '0;
            prev_q   <= '0;
            ackv_q   <= 1'b0;
            ackp_q   <= 1'b0;
            ackpgn_q <= 18'h0;
        end
        else
        begin
            act_q    <= act_d;
            log_q    <= log_d;
            first_q  <= first_d;
            prev_q   <= diag_i;
            ackv_q   <= ackv_d;
            ackp_q   <= ackp_d;
            ackpgn_q <= ackpgn_d;
        end
    end

    assign ack_valid_o = ackv_q;
    assign ack_pos_o   = ackp_q;
    assign ack_pgn_o   = ackpgn_q;

    // ====
    // Encoders
    jdr_diag_type a;
    logic [4:0]   fmi;
    logic [2:0]   temp;

    always_comb
    begin
        a = act_q;
        // R2 pairs 0 or 1, R3 byte one
        bf_live[7:0]   = {1'b0, a.position_err, 1'b0, a.spring_check,
                          1'b0, a.supply_low | a.supply_high, 1'b0, a.internal_fault};
        // R4 byte two
        bf_live[15:8]  = {1'b0, a.zero_drive, 1'b0, a.derating,
                          1'b0, a.temp_sensor, 1'b0, a.config_err};
        // R5 byte three
        bf_live[23:16] = {1'b0, a.analog_high | a.analog_low, 1'b0, a.loss_demand,
                          1'b0, a.tracking, 1'b0, a.run_shutdown};
        // R6 byte four, top pairs fixed
        bf_live[31:24] = {`JDR_ST_NA, `JDR_ST_NA, 1'b0,
                          a.can_no_signal | a.can_range, 1'b0, a.pwm_fail};
        // R9 priority chain, R10 top, R11 rest
        if (a.internal_fault)     fmi = 5'h0C;
        else if (a.run_shutdown)  fmi = 5'h05;
        else if (a.zero_drive)    fmi = 5'h00;
        else if (a.loss_demand)   fmi = 5'h0E;
        else if (a.analog_high)   fmi = 5'h0F;
        else if (a.analog_low)    fmi = 5'h11;
        else if (a.pwm_fail)      fmi = 5'h08;
        else if (a.can_no_signal) fmi = 5'h09;
        else if (a.position_err)  fmi = 5'h07;
        else if (a.supply_low)    fmi = 5'h04;
        else if (a.derating)      fmi = 5'h0F;
        else if (a.supply_high)   fmi = 5'h03;
        else if (a.tracking)      fmi = 5'h02;
        else if (a.temp_sensor)   fmi = 5'h0C;
        else if (a.spring_check)  fmi = 5'h07;
        else if (a.can_range)     fmi = 5'h10;
        else if (a.config_err)    fmi = 5'h0D;
        else                      fmi = `JDR_FMI_NONE;
        // R12 overtemperature, R13 sensor error
        if (a.temp_sensor)        temp = `JDR_TEMP_ERROR;
        else if (a.zero_drive)    temp = `JDR_TEMP_ZERO;
        else if (a.derating)      temp = `JDR_TEMP_DERATE;
        else                      temp = `JDR_TEMP_NORMAL;
        // R8 code low, status high
        fmi_live = {temp, fmi};
    end

    // ====
    // Periodic frames and broadcast stop
    jdr_frame_type bf_q, bf_d, fm_q, fm_d;
    logic          stopped_d;
    logic [31:0]   hold_q, hold_d;

    function automatic logic [63:0] place(input logic [31:0] v,
                                          input int unsigned n,
                                          input logic [2:0] s);
        logic [63:0] r;
        r = {8{`JDR_FILL_BYTE}};
        for (int i = 0; i < 8; i++)
            if (i >= int'(s) && i < int'(s) + int'(n))
                r[i*8 +: 8] = v[(i - int'(s))*8 +: 8];
        return r;
    endfunction : place

    always_comb
    begin
        stopped_d = stopped_q;
        hold_d    = hold_q;
        // R18 stop, start and hold
        if (ctrl_q[`JDR_CTRL_DM13_EN])
        begin
            if (dm13_start)
                stopped_d = 1'b0;
            else if (dm13_stop || (dm13_hold && stopped_q))
            begin
                stopped_d = 1'b1;
                hold_d    = 32'(HOLD_CYCLES - 1);
            end
            else if (stopped_q && hold_q == 32'h0)
                stopped_d = 1'b0;
            else if (stopped_q)
                hold_d = hold_q - 32'h1;
        end
        else
            stopped_d = 1'b0;
        bf_d       = bf_q;
        fm_d       = fm_q;
        bf_d.valid = 1'b0;
        fm_d.valid = 1'b0;
        // R23 snapshot at transmit tick
        if (bf_tick && ctrl_q[`JDR_CTRL_BF_EN] && !stopped_q)
        begin
            bf_d.valid = 1'b1;
            // R7 priority into identifier
            bf_d.id    = {bf_cfg_q.prio, bf_cfg_q.pgn, ctrl_q[`JDR_CTRL_SA_LSB +: 8]};
            // R1 four bytes from start
            bf_d.data  = place(bf_live, 4, bf_cfg_q.start);
        end
        if (fmi_tick && ctrl_q[`JDR_CTRL_FMI_EN] && !stopped_q)
        begin
            fm_d.valid = 1'b1;
            fm_d.id    = {fmi_cfg_q.prio, fmi_cfg_q.pgn, ctrl_q[`JDR_CTRL_SA_LSB +: 8]};
            fm_d.data  = place({24'h0, fmi_live}, 1, fmi_cfg_q.start);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stopped_q <= 1'b0;
            hold_q    <= 32'h0;
            bf_q      <= '0;
            fm_q      <= '0;
        end
        else
        begin
            stopped_q <= stopped_d;
            hold_q    <= hold_d;
            bf_q      <= bf_d;
            fm_q      <= fm_d;
        end
    end

    assign bf_frame_o      = bf_q;
    assign fmi_frame_o     = fm_q;
    assign bcast_stopped_o = stopped_q;

    // ====
    // Software identification stream
    jdr_sw_state_type sw_q, sw_d;
    logic [7:0]       idx_q, idx_d, sb_q, sb_d;
    logic             sv_q, sv_d, sl_q, sl_d;

    function automatic logic [7:0] sw_byte(input logic [7:0] i);
        if (i == 8'h00)
            return `JDR_SOFT_FIELDS;
        if (int'(i) > ID_LEN)
            return `JDR_SOFT_DELIM;
        return SW_ID[8*(ID_LEN - int'(i)) +: 8];
    endfunction : sw_byte

    always_comb
    begin
        sw_d  = sw_q;
        idx_d = idx_q;
        sb_d  = sb_q;
        sv_d  = sv_q;
        sl_d  = sl_q;
        case (sw_q)
            SW_IDLE:
            begin
                // R19 only on request
                if (soft_req)
                begin
                    sw_d  = SW_SEND;
                    idx_d = 8'h01;
                    // R20 count, text, delimiter
                    sb_d  = sw_byte(8'h00);
                    sv_d  = 1'b1;
                    sl_d  = 1'b0;
                end
            end
            SW_SEND:
            begin
                if (soft_ready)
                begin
                    if (sl_q)
                    begin
                        sw_d = SW_IDLE;
                        sv_d = 1'b0;
                        sl_d = 1'b0;
                    end
                    else
                    begin
                        sb_d  = sw_byte(idx_q);
                        sl_d  = int'(idx_q) == ID_LEN + 1;
                        idx_d = idx_q + 8'h01;
                    end
                end
            end
            default: sw_d = SW_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sw_q  <= SW_IDLE;
            idx_q <= 8'h00;
            sb_q  <= 8'h00;
            sv_q  <= 1'b0;
            sl_q  <= 1'b0;
        end
        else
        begin
            sw_q  <= sw_d;
            idx_q <= idx_d;
            sb_q  <= sb_d;
            sv_q  <= sv_d;
            sl_q  <= sl_d;
        end
    end

    // Fixed id, source address only
    logic [28:0] sid_q;
    always_ff @(posedge clk)
    begin
        if (rst)
            sid_q <= 29'h0;
        else
            sid_q <= {`JDR_SOFT_PRIO, `JDR_PGN_SOFT, ctrl_q[`JDR_CTRL_SA_LSB +: 8]};
    end

    assign soft_valid_o = sv_q;
    assign soft_byte_o  = sb_q;
    assign soft_last_o  = sl_q;
    assign soft_id_o    = sid_q;

endmodule : jdr_reporter

// [bench/jdr_reporter_asserts.sv]
/* Port checker of the diagnostic reporter.
   Assumes a bind onto jdr_reporter, one clock domain. */
module jdr_reporter_asserts
(
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_ack_o,
    input wire logic                   bf_tick,
    input wire logic                   req_dm11,
    input wire logic                   req_dm3,
    input wire logic                   dm13_start,
    input wire logic                   soft_ready,
    input wire jdr_pkg::jdr_frame_type bf_frame_o,
    input wire logic                   ack_valid_o,
    input wire logic [17:0]            ack_pgn_o,
    input wire logic                   bcast_stopped_o,
    input wire logic                   soft_valid_o,
    input wire logic                   soft_last_o,
    input wire logic [7:0]             soft_byte_o,
    input wire logic [28:0]            soft_id_o
);
    import jdr_pkg::*;
    // ====
    // Properties
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    property p_wb_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus ack late");
    property p_ack_cause; ack_valid_o |-> $past(req_dm11 || req_dm3); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_ack_pgn;
        ack_valid_o |-> ack_pgn_o == ($past(req_dm11) ? 18'h0FED3 : 18'h0FECC);
    endproperty
    a_ack_pgn: assert property (p_ack_pgn) else $error("ack group wrong");
    property p_quiet; $past(bcast_stopped_o) |-> !bf_frame_o.valid; endproperty
    a_quiet: assert property (p_quiet) else $error("frame while stopped");
    property p_start; dm13_start |=> !bcast_stopped_o; endproperty
    a_start: assert property (p_start) else $error("start ignored");
    property p_bf_tick; bf_frame_o.valid |-> $past(bf_tick); endproperty
    a_bf_tick: assert property (p_bf_tick) else $error("frame without tick");
    property p_soft_head;
        $rose(soft_valid_o) |-> soft_byte_o == 8'h01 && soft_id_o[28:8] == {3'h6, 18'h0FEDA};
    endproperty
    a_soft_head: assert property (p_soft_head) else $error("bad stream head");
    property p_soft_hold;
        soft_valid_o && !soft_ready |=> soft_valid_o && $stable(soft_byte_o);
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("byte lost on stall");
    property p_soft_last; soft_last_o |-> soft_byte_o == 8'h2A; endproperty
    a_soft_last: assert property (p_soft_last) else $error("bad delimiter");
    c_stall: cover property (soft_valid_o && !soft_ready);
    c_stop: cover property ($fell(bcast_stopped_o));
    c_ack: cover property (ack_valid_o);
endmodule : jdr_reporter_asserts

// [bench/jdr_ecu_model.sv]
/* Engine control unit stand-in taking the identification stream.
   Assumes the reporter's stream outputs on the same clock. */
module jdr_ecu_model
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        slow,
    input wire logic        soft_valid_o,
    input wire logic [7:0]  soft_byte_o,
    output logic            soft_ready,
    output logic [79:0]     rx_q,
    output int              n_got
);
    logic pace_q;
    // Slow mode stalls every other edge to test the hold
    assign soft_ready = !slow || pace_q;
    always_ff @(posedge clk)
    begin
        pace_q <= !rst && !pace_q;
        if (rst)
            n_got <= 0;
        else if (soft_valid_o && soft_ready)
        begin
            rx_q <= {rx_q[71:0], soft_byte_o};
            n_got <= n_got + 1;
        end
    end
endmodule : jdr_ecu_model

// [bench/jdr_reporter_tb.sv]
/* Self-checking bench of the diagnostic reporter.
   Assumes the rtl package, header and design compiled first. */
`include "jdr_consts.svh"
module jdr_reporter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import jdr_pkg::*;
    localparam logic [63:0] SWID = 64'h4142_4344_3031_3233;
    localparam logic [7:0] BF = 1, FM = 2, D11 = 4, D3 = 8, STP = 16, STA = 32, HLD = 64, SFT = 128;
    logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, soft_ready, ack_valid_o, ack_pos_o;
    logic bcast_stopped_o, soft_valid_o, soft_last_o, slow;
    logic bf_tick, fmi_tick, req_dm11, req_dm3, dm13_stop, dm13_start, dm13_hold, soft_req;
    logic [7:0] wb_adr_i, soft_byte_o, pl;
    logic [3:0] wb_sel_i;
    logic [2:0] t;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [17:0] ack_pgn_o;
    logic [28:0] soft_id_o;
    logic [79:0] rx_q;
    jdr_diag_type diag_i, d;
    jdr_frame_type bf_frame_o, fmi_frame_o;
    int failures, n_compared, n_got, cycles;
    int pos_tab [17] = '{4, 13, 2, 5, 9, 1, 6, 1, 3, 13, 12, 11, 11, 10, 7, 8, 0};
    int fmi_tab [17] = '{13, 16, 7, 12, 2, 3, 15, 4, 7, 9, 8, 17, 15, 14, 0, 5, 12};
    assign {soft_req, dm13_hold, dm13_start, dm13_stop, req_dm3, req_dm11, fmi_tick, bf_tick} = pl;
    jdr_reporter #(.HOLD_CYCLES(50), .SW_ID(SWID)) jdr_reporter_i (.*);
    jdr_ecu_model jdr_ecu_model_i (.*);
    // ====
    // Helpers
    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [95:0] g, input logic [95:0] e);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, v};
        do
            @(posedge clk);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    task automatic pulse(input logic [7:0] m);
        pl <= m;
        @(posedge clk);
        pl <= 8'h0;
        @(posedge clk);
    endtask : pulse
    function automatic logic [31:0] bf_exp(input jdr_diag_type x);
        bf_exp = 32'hF000_0000;
        for (int j = 0; j < 17; j++)
            if (x[j])
                bf_exp[2 * pos_tab[j]] = 1'b1;
    endfunction : bf_exp
    // ====
    // Sequence
    initial
    begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, pl, slow, diag_i} = '0;
        wb_sel_i = 4'hF;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`JDR_OFF_CTRL, 32'h0);
        rd(`JDR_OFF_BF_CFG, `JDR_BF_CFG_RST);
        rd(8'h3C, 32'h0);
        wb(1'b1, `JDR_OFF_CTRL, 32'h0025_007F);
        wb(1'b1, `JDR_OFF_BF_CFG, 32'h0067_F802);
        wb(1'b1, `JDR_OFF_FMI_CFG, 32'h00A7_F80F);
        wb(1'b1, `JDR_OFF_ACTIVE, 32'hFFFF_FFFF);
        for (int i = 0; i < 17; i++)
        begin
            d = 17'h1 | (17'h1 << i);
            diag_i <= d;
            t = (i == 3) ? 3'd6 : (i == 14) ? 3'd0 : (i == 6) ? 3'd1 : 3'd2;
            repeat (3) @(posedge clk);
            rd(`JDR_OFF_STATUS, {t, fmi_tab[i][4:0]});
            rd(`JDR_OFF_BITFIELD, bf_exp(d));
        end
        pulse(BF);
        chk(bf_frame_o, {4'hB, 18'h0FF00, 8'h25, 16'hFFFF, bf_exp(d), 16'hFFFF});
        pulse(FM);
        chk(fmi_frame_o, {4'hD, 18'h0FF01, 8'h25, 8'h4C, 56'hFF_FFFF_FFFF_FFFF});
        rd(`JDR_OFF_ACTIVE, 32'h1_0001);
        rd(`JDR_OFF_LOGGED, 32'h1_FFFF);
        rd(`JDR_OFF_DM2, 32'h0_FFFE);
        diag_i <= '0;
        repeat (3) @(posedge clk);
        rd(`JDR_OFF_DM2, 32'h1_FFFF);
        wb(1'b1, `JDR_OFF_CLRCMD, 32'h4);
        rd(`JDR_OFF_LOGGED, 32'h0);
        diag_i <= 17'h1;
        repeat (3) @(posedge clk);
        wb(1'b1, `JDR_OFF_CLRCMD, 32'h4);
        rd(`JDR_OFF_LOGGED, 32'h1);
        pulse(D11);
        chk({ack_valid_o, ack_pos_o, ack_pgn_o}, {2'b11, 18'h0FED3});
        rd(`JDR_OFF_STATUS, 32'h5F);
        wb(1'b1, `JDR_OFF_CTRL, 32'h0025_015F);
        pulse(D3);
        chk({ack_valid_o, ack_pos_o, ack_pgn_o}, {2'b10, 18'h0FECC});
        rd(`JDR_OFF_LOGGED, 32'h1);
        pulse(D11);
        chk(ack_valid_o, 1'b0);
        pulse(STP);
        repeat (40) @(posedge clk);
        pulse(HLD);
        repeat (40) @(posedge clk);
        pulse(BF);
        chk({bcast_stopped_o, bf_frame_o.valid}, 2'b10);
        repeat (10) @(posedge clk);
        chk(bcast_stopped_o, 1'b0);
        pulse(STP);
        pulse(STA);
        slow <= 1'b1;
        pulse(SFT);
        wait (n_got == 10);
        chk(rx_q, {8'h01, SWID, 8'h2A});
        finish_test();
    end
endmodule : jdr_reporter_tb
bind jdr_reporter jdr_reporter_asserts jdr_reporter_asserts_i (.*);
